// ===== core/srtr_device.sv
`timescale 1ns/1ps
// Behaviour
// - Tag bit follows LSB, equals channel
// - Host gives over 16 clocks with tag
// - Chain bit makes status pin chain input
// - First converter regular, downstream chained
// - Chain bits reappear after 16 or 24
// - Host holds select low whole chain
// - First word is own result
// - Later words upstream data, else repeat
// - New frame restarts with own result
// - No convert start keeps previous result
// - Tag off: exactly 16 clocks
// - Tag on, manual: tag then zeros
// - Tag plus seven zeros; chain 24
// - Power-on or soft reset resets device
// - Reset sets ones, first frame ones
// - Host slows serial clock in chain; host here keeps one HALF_DIV in every frame
module srtr_device (
  // Link side
  srtr_link_if.dev lnk,
  // Internal conversion clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample inputs
  input wire logic [srtr_pkg::RES_W-1:0] ch0_sample,
  input wire logic [srtr_pkg::RES_W-1:0] ch1_sample,
  input wire logic manual_channel,
  // Config word write
  input wire logic cfg_wr,
  input wire logic [srtr_pkg::CFG_W-1:0] cfg_wdata,
  // Status
  output logic [srtr_pkg::CFG_W-1:0] config_word,
  output logic [srtr_pkg::RES_W-1:0] result_word,
  output logic result_channel,
  output logic conv_done,
  output logic [7:0] frame_count
);

  logic soft_q;
  logic dev_rst_n;
  logic [srtr_pkg::CFG_W-1:0] config_q;
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic cv_s1;
  logic cv_s2;
  logic cv_s3;
  logic conv_start;
  logic cs_rise;
  logic next_ch;
  logic [srtr_pkg::RES_W-1:0] result_q;
  logic chan_q;
  logic done_q;
  logic ones_q;
  logic [7:0] frames_q;
  logic [srtr_pkg::RES_W-1:0] pub_res_q;
  logic pub_tag_q;
  logic pub_ones_q;
  logic pub_tagen_q;
  logic pub_chain_q;
  logic frame_rst;
  logic started_q;
  logic [srtr_pkg::FRAME_W-1:0] sh_q;
  logic [srtr_pkg::FRAME_W-1:0] load_word;
  logic [srtr_pkg::FRAME_W-1:0] cur_word;
  logic [4:0] top_idx;
  logic top_bit;
  logic in_bit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= cfg_wr & ~cfg_wdata[srtr_pkg::BIT_SOFT_RST];
    end
  end

  assign dev_rst_n = rst_n & ~soft_q;

  always_ff @(posedge clk or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      config_q <= srtr_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      config_q <= cfg_wdata;
    end
  end

  // Select and convert-start synchronisers
  always_ff @(posedge clk or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else begin
      cs_s1 <= lnk.cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  always_ff @(posedge clk or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      cv_s1 <= 1'b1;
      cv_s2 <= 1'b1;
      cv_s3 <= 1'b1;
    end else begin
      cv_s1 <= lnk.convert_start_n;
      cv_s2 <= cv_s1;
      cv_s3 <= cv_s2;
    end
  end

  assign conv_start = cv_s3 & ~cv_s2;
  assign cs_rise = cs_s2 & ~cs_s3;
  assign next_ch = config_q[srtr_pkg::BIT_AUTO] ? ~chan_q : manual_channel;

  // Result changes only on convert start
  always_ff @(posedge clk or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      result_q <= '1;
      chan_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= conv_start;
      if (conv_start) begin
        result_q <= next_ch ? ch1_sample : ch0_sample;
        chan_q <= next_ch;
      end
    end
  end

  // First frame after reset reads ones
  always_ff @(posedge clk or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      ones_q <= 1'b1;
    end else if (cs_rise) begin
      ones_q <= 1'b0;
    end
  end

  // Frames completed
  always_ff @(posedge clk or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      frames_q <= 8'h00;
    end else if (cs_rise) begin
      frames_q <= frames_q + 8'h01;
    end
  end

  // Snapshot for the link, frozen while selected
  always_ff @(posedge clk or negedge dev_rst_n) begin
    if (!dev_rst_n) begin
      pub_res_q <= '1;
      pub_tag_q <= 1'b1;
      pub_ones_q <= 1'b1;
      pub_tagen_q <= 1'b1;
      pub_chain_q <= 1'b1;
    end else if (cs_s2) begin
      pub_res_q <= result_q;
      pub_tag_q <= chan_q;
      pub_ones_q <= ones_q;
      pub_tagen_q <= config_q[srtr_pkg::BIT_TAG_EN];
      pub_chain_q <= config_q[srtr_pkg::BIT_CHAIN];
    end
  end

  always_comb begin
    if (pub_ones_q) begin
      load_word = '1;
    end else if (pub_tagen_q) begin
      load_word = {pub_res_q, pub_tag_q, srtr_pkg::TRAIL_ZEROS};
    end else begin
      load_word = {srtr_pkg::PAD_ZEROS, pub_res_q};
    end
  end

  // Delay line 16 or 24 long
  assign top_idx = pub_tagen_q ? srtr_pkg::TOP_TAG : srtr_pkg::TOP_NOTAG;
  assign cur_word = started_q ? sh_q : load_word;
  assign top_bit = cur_word[top_idx];
  // Upstream bits, or own word again
  assign in_bit = pub_chain_q ? lnk.chain_data_in : top_bit;
  assign lnk.serial_out = top_bit;

  assign frame_rst = lnk.cs_n | ~dev_rst_n;

  // Shift and sample on falling edge
  always_ff @(negedge lnk.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      started_q <= 1'b0;
      sh_q <= '0;
    end else begin
      started_q <= 1'b1;
      sh_q <= {cur_word[srtr_pkg::FRAME_W-2:0], in_bit};
    end
  end

  // Status outputs
  assign config_word = config_q;
  assign result_word = result_q;
  assign result_channel = chan_q;
  assign conv_done = done_q;
  assign frame_count = frames_q;

endmodule

// ===== core/srtr_host.sv
`timescale 1ns/1ps
module srtr_host #(
  parameter logic [7:0] HALF_DIV = srtr_pkg::SCLK_HALF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link side
  srtr_link_if.host lnk
);

  srtr_pkg::srtr_hstate_t st_q;
  logic [7:0] tmr_q;
  logic [7:0] bits_q;
  logic [7:0] len_q;
  logic [31:0] rx_q;
  logic [7:0] conv_q;
  logic sclk_q;
  logic cs_q;
  logic done_q;
  logic so_s1;
  logic so_s2;
  logic wr;
  logic hit;
  logic go;
  logic tick;
  logic frame_end;

  assign wr = psel & penable & pwrite;
  assign hit = (paddr == srtr_pkg::REG_CTRL) | (paddr == srtr_pkg::REG_LEN) |
               (paddr == srtr_pkg::REG_STAT) | (paddr == srtr_pkg::REG_DATA);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign go = wr & (paddr == srtr_pkg::REG_CTRL) & pwdata[srtr_pkg::CTRL_GO] &
              (st_q == srtr_pkg::SRTR_IDLE);
  assign tick = (tmr_q == 8'h00);
  assign frame_end = (st_q == srtr_pkg::SRTR_LOW) & tick & (bits_q == 8'h00);

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == srtr_pkg::REG_LEN) begin
      prdata = {24'h00_0000, len_q};
    end else if (paddr == srtr_pkg::REG_STAT) begin
      prdata = {30'h0000_0000, done_q, st_q != srtr_pkg::SRTR_IDLE};
    end else if (paddr == srtr_pkg::REG_DATA) begin
      prdata = rx_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_q <= srtr_pkg::LEN_RESET;
    end else if (wr && paddr == srtr_pkg::REG_LEN) begin
      len_q <= pwdata[7:0];
    end
  end

  // Done flag, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (frame_end) begin
      done_q <= 1'b1;
    end else if (wr && paddr == srtr_pkg::REG_STAT && pwdata[srtr_pkg::STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Convert-start low pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= 8'h00;
    end else if (wr && paddr == srtr_pkg::REG_CTRL && pwdata[srtr_pkg::CTRL_CONV]) begin
      conv_q <= srtr_pkg::CONV_LOW;
    end else if (conv_q != 8'h00) begin
      conv_q <= conv_q - 8'h01;
    end
  end

  // Serial data synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      so_s1 <= 1'b0;
      so_s2 <= 1'b0;
    end else begin
      so_s1 <= lnk.serial_out;
      so_s2 <= so_s1;
    end
  end

  // Frame sequencer and clock divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= srtr_pkg::SRTR_IDLE;
      tmr_q <= 8'h00;
      bits_q <= 8'h00;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      rx_q <= 32'h0000_0000;
    end else begin
      if (!tick) begin
        tmr_q <= tmr_q - 8'h01;
      end
      unique case (st_q)
        srtr_pkg::SRTR_IDLE: begin
          if (go && len_q != 8'h00) begin
            cs_q <= 1'b0;
            bits_q <= len_q;
            tmr_q <= srtr_pkg::CS_SETUP - 8'h01;
            st_q <= srtr_pkg::SRTR_SETUP;
          end
        end
        srtr_pkg::SRTR_SETUP: begin
          if (tick) begin
            sclk_q <= 1'b1;
            bits_q <= bits_q - 8'h01;
            tmr_q <= HALF_DIV - 8'h01;
            st_q <= srtr_pkg::SRTR_HIGH;
          end
        end
        srtr_pkg::SRTR_HIGH: begin
          if (tick) begin
            rx_q <= {rx_q[30:0], so_s2};
            sclk_q <= 1'b0;
            tmr_q <= HALF_DIV - 8'h01;
            st_q <= srtr_pkg::SRTR_LOW;
          end
        end
        srtr_pkg::SRTR_LOW: begin
          if (tick && bits_q == 8'h00) begin
            cs_q <= 1'b1;
            tmr_q <= srtr_pkg::CS_GAP - 8'h01;
            st_q <= srtr_pkg::SRTR_GAP;
          end else if (tick) begin
            sclk_q <= 1'b1;
            bits_q <= bits_q - 8'h01;
            tmr_q <= HALF_DIV - 8'h01;
            st_q <= srtr_pkg::SRTR_HIGH;
          end
        end
        srtr_pkg::SRTR_GAP: begin
          if (tick) begin
            st_q <= srtr_pkg::SRTR_IDLE;
          end
        end
        default: begin
          st_q <= srtr_pkg::SRTR_IDLE;
        end
      endcase
    end
  end

  assign lnk.sclk = sclk_q;
  assign lnk.cs_n = cs_q;
  assign lnk.convert_start_n = (conv_q == 8'h00);

endmodule

// ===== core/srtr_link_if.sv
`timescale 1ns/1ps
interface srtr_link_if;
  logic cs_n;
  logic sclk;
  logic convert_start_n;
  logic serial_out;
  logic chain_data_in;
  modport dev (
    input cs_n,
    input sclk,
    input convert_start_n,
    input chain_data_in,
    output serial_out
  );
  modport host (
    output cs_n,
    output sclk,
    output convert_start_n,
    input serial_out
  );
endinterface

// ===== core/srtr_pkg.sv
package srtr_pkg;
  // Result and frame widths
  localparam int RES_W = 16;
  localparam int FRAME_W = 24;
  localparam int CFG_W = 12;
  localparam logic [4:0] TOP_TAG = 5'h17;
  localparam logic [4:0] TOP_NOTAG = 5'h0F;
  localparam logic [6:0] TRAIL_ZEROS = 7'h00;
  localparam logic [7:0] PAD_ZEROS = 8'h00;
  // Config word fields and reset value
  localparam logic [CFG_W-1:0] CFG_RESET = 12'hFFF;
  localparam int BIT_SOFT_RST = 0;
  localparam int BIT_TAG_EN = 1;
  localparam int BIT_CHAIN = 5;
  localparam int BIT_AUTO = 11;
  // Host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam int CTRL_GO = 0;
  localparam int CTRL_CONV = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [7:0] LEN_RESET = 8'h10;
  // Host timing counts in clk cycles
  localparam logic [7:0] SCLK_HALF = 8'h04;
  localparam logic [7:0] CS_SETUP = 8'h04;
  localparam logic [7:0] CS_GAP = 8'h04;
  localparam logic [7:0] CONV_LOW = 8'h04;
  // Host sequencer states
  typedef enum logic [2:0] {
    SRTR_IDLE = 3'b000,
    SRTR_SETUP = 3'b001,
    SRTR_HIGH = 3'b010,
    SRTR_LOW = 3'b011,
    SRTR_GAP = 3'b100
  } srtr_hstate_t;
endpackage

// ===== test/srtr_chk.sv
`timescale 1ns/1ps
module srtr_chk (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Link
  input logic cs_n,
  input logic sclk,
  input logic convert_start_n,
  input logic serial_out,
  input logic chain_data_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sclk_in_frame;
    $rose(sclk) |-> !cs_n;
  endproperty
  a_sclk_in_frame: assert property (p_sclk_in_frame) else $error("sclk outside frame");
  property p_cs_setup;
    $fell(cs_n) |-> !sclk[*3] ##[1:2] $rose(sclk);
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("bad select setup");
  property p_sclk_high;
    $rose(sclk) |-> sclk[*4] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("bad sclk high");
  property p_sclk_low;
    $fell(sclk) && !cs_n |-> !sclk[*4];
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("bad sclk low");
  property p_out_steady;
    !cs_n && sclk && $past(sclk) |-> $stable(serial_out);
  endproperty
  a_out_steady: assert property (p_out_steady) else $error("data moved in high");
  property p_conv_pulse;
    $fell(convert_start_n) |-> !convert_start_n[*3] ##[1:2] convert_start_n;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("bad convert pulse");
  property p_cs_gap;
    $rose(cs_n) |-> cs_n[*4];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select gap short");
  property p_frame_end;
    $rose(cs_n) |-> !$past(sclk, 4) && $past(sclk, 5);
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("bad frame end");
  c_frame: cover property ($rose(cs_n));
  c_conv: cover property ($fell(convert_start_n));
  c_chain: cover property (!cs_n && chain_data_in && $fell(sclk));
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic cmp = 1'b0;
  logic man = 1'b0;
  logic cfg_wr = 1'b0;
  logic pready, pslverr, conv_done, res_ch;
  logic [7:0] paddr = 8'h00;
  logic [7:0] f_cnt;
  logic [31:0] pwdata = 32'h0, prdata, rv, up;
  logic [15:0] s0, s1, res;
  logic [15:0] ch0 = 16'h0;
  logic [15:0] ch1 = 16'h0;
  logic [11:0] cfg_wdata = 12'h000;
  logic [11:0] cfg_q;
  logic [5:0] ci = 6'h00;
  logic [64:0] q[$];
  string nm;
  int seed = 33;
  int err_total = 0;
  int total_checks = 0;
  srtr_link_if lnk();
  srtr_device srtr_device_inst(.lnk(lnk), .clk(clk), .rst_n(rst_n), .ch0_sample(ch0),
    .ch1_sample(ch1), .manual_channel(man), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .config_word(cfg_q), .result_word(res), .result_channel(res_ch),
    .conv_done(conv_done), .frame_count(f_cnt));
  srtr_host #(.HALF_DIV(8'h04)) srtr_host_inst(.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk));
  srtr_chk srtr_chk_inst(.clk(clk), .rst_n(rst_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .convert_start_n(lnk.convert_start_n), .serial_out(lnk.serial_out),
    .chain_data_in(lnk.chain_data_in));
  always #2 clk = ~clk;
  always @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      lnk.chain_data_in <= 1'b0;
      ci <= 6'h00;
    end else begin
      lnk.chain_data_in <= up[5'd31 - ci[4:0]];
      ci <= ci + 6'h01;
    end
  end
  task give_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task tmo(input string n, input int k);
    if (k >= 400) begin
      err_total++;
      $display("ERROR %s expected done seen timeout", n);
      give_verdict();
    end
  endtask
  // Compare read data against oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && cmp) begin
      chk(nm, q[0][63:32], prdata & q[0][31:0]);
      chk("pslverr", {31'h0, q[0][64]}, {31'h0, pslverr});
      void'(q.pop_front());
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 400) begin
      n++;
      @(posedge clk);
    end
    tmo("pready", n);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk_rd(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic se);
    nm = n;
    q.push_back({se, e, m});
    cmp <= 1'b1;
    apb(1'b0, a, 32'h0);
    cmp <= 1'b0;
  endtask
  task frame(input logic [7:0] len, input logic [31:0] e, input logic [31:0] m);
    int n;
    n = 0;
    apb(1'b1, srtr_pkg::REG_LEN, {24'h0, len});
    apb(1'b1, srtr_pkg::REG_CTRL, 32'h1);
    rv = 32'h1;
    while (rv[srtr_pkg::STAT_BUSY] !== 1'b0 && n < 400) begin
      n++;
      apb(1'b0, srtr_pkg::REG_STAT, 32'h0);
    end
    tmo("frame", n);
    chk_rd("rx_data", srtr_pkg::REG_DATA, e, m, 1'b0);
    chk_rd("stat_done", srtr_pkg::REG_STAT, 32'h2, 32'h3, 1'b0);
    apb(1'b1, srtr_pkg::REG_STAT, 32'h2);
    chk_rd("stat_clear", srtr_pkg::REG_STAT, 32'h0, 32'h3, 1'b0);
  endtask
  task conv();
    int n;
    n = 0;
    apb(1'b1, srtr_pkg::REG_CTRL, 32'h2);
    while (conv_done !== 1'b1 && n < 400) begin
      n++;
      @(posedge clk);
    end
    tmo("conv", n);
  endtask
  task cfg(input logic [11:0] v);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  initial begin
    up = $random(seed);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("config_word", 32'h00000FFF, {20'h0, cfg_q});
    chk_rd("len_reset", srtr_pkg::REG_LEN, {24'h0, srtr_pkg::LEN_RESET}, 32'hFFFFFFFF, 1'b0);
    frame(8'h18, 32'h00FFFFFF, 32'h00FFFFFF);
    s0 = 16'($random(seed));
    s1 = 16'($random(seed));
    ch0 <= s0;
    ch1 <= s1;
    cfg(12'h001);
    conv();
    frame(8'h20, {s0, s0}, 32'hFFFFFFFF);
    man <= 1'b1;
    cfg(12'h003);
    conv();
    chk("result_channel", 32'h1, {31'h0, res_ch});
    frame(8'h20, {s1, 1'b1, 7'h00, s1[15:8]}, 32'hFFFFFFFF);
    ch1 <= ~s1;
    cfg(12'h021);
    frame(8'h20, {s1, up[31:16]}, 32'hFFFFFFFF);
    frame(8'h10, {up[31:16], s1}, 32'hFFFFFFFF);
    cfg(12'h023);
    conv();
    up = $random(seed);
    frame(8'h20, {~s1, 1'b1, 7'h00, up[31:24]}, 32'hFFFFFFFF);
    cfg(12'h803);
    conv();
    chk("result_channel", 32'h0, {31'h0, res_ch});
    frame(8'h18, {8'h00, s0, 8'h00}, 32'h00FFFFFF);
    chk_rd("unmapped", 8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
    chk("frame_count", 32'h7, {24'h0, f_cnt});
    cfg(12'h000);
    repeat (3) @(posedge clk);
    chk("result_word", 32'h0000FFFF, {16'h0, res});
    chk("config_word", {20'h0, srtr_pkg::CFG_RESET}, {20'h0, cfg_q});
    chk("frame_count", 32'h0, {24'h0, f_cnt});
    frame(8'h18, 32'h00FFFFFF, 32'h00FFFFFF);
    give_verdict();
  end
endmodule
